// ==== design/tcc_edge_filter.v ====
`timescale 1ns/1ps
`default_nettype none

module tcc_edge_filter (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Pin and sampling strobe
  input wire pin,
  input wire sample_tick,
  // Filtered level
  output reg level
);

  reg sync1_reg;
  reg sync2_reg;
  reg sample_reg;

  // Two-stage synchroniser, then level accepted after two equal samples
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sample_reg <= 1'b0;
      level <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      if (sample_tick) begin
        sample_reg <= sync2_reg;
        if (sample_reg == sync2_reg) begin
          level <= sync2_reg; // R16
        end
      end
    end
  end

endmodule // tcc_edge_filter

`default_nettype wire

// ==== design/tcc_timer.v ====
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.vh"

// Summary of operation
// (R1) Match-clear mode needs both compare values nonzero
// (R2) Capture proceeds during read; interrupt still raised
// (R3) Stop timer before changing input A edge
// (R4) Overflow flag sets on FFFF to 0000
// (R5) Clearing flag before count 0001 is ignored
// (R6) Avoid compare writes near the match time
// (R7) Counter reads never capture into register B
// (R8) Stopped timer ignores both input pins
// (R9) Input A as clock blocks its capture
// (R10) Both edges on input A: no capture
// (R11) Trigger pulse must exceed two count clocks
// (R12) Capture at count-clock fall, interrupt at rise
// (R13) Late compare rewrite may misfire or miss clear
// (R14) Compare-mode register ignores capture triggers
// (R15) High input after reset gives immediate edge
// (R16) Noise filter needs two equal samples
// (R17) Stop timer before clock-stop modes
// (R18) Start is not aligned to count clock
// (R19) Sixteen-bit up counter, cleared by reset
module tcc_timer #(
  parameter ADDR_W = 8,
  parameter CNT_W = 16,
  parameter PRE_W = 6
) (
  // APB clock and reset
  input wire pclk,
  input wire presetn,
  // APB request
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  // APB answer
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Timer input pins
  input wire timer_input_a,
  input wire timer_input_b,
  // Events and status
  output reg capture_match_irq,
  output reg capture_b_irq,
  output reg overflow_flag
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------

  // Valid edge test for one filtered input
  function edge_hit;
    input [1:0] sel;
    input prev;
    input cur;
    begin
      case (sel)
        `TCC_ES_FALL: edge_hit = prev & ~cur;
        `TCC_ES_RISE: edge_hit = ~prev & cur;
        `TCC_ES_BOTH: edge_hit = prev ^ cur;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  // Divider mask for the selected count clock
  function [PRE_W-1:0] div_mask;
    input [1:0] sel;
    begin
      case (sel)
        `TCC_CLK_FX: div_mask = `TCC_MASK_FX;
        `TCC_CLK_FX_DIV4: div_mask = `TCC_MASK_DIV4;
        default: div_mask = `TCC_MASK_DIV64;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg [1:0] op_mode_reg;
  reg [7:0] prescaler_mode_reg;
  reg [1:0] capctl_reg;
  reg [CNT_W-1:0] main_counter_16;
  reg [CNT_W-1:0] capture_compare_a;
  reg [CNT_W-1:0] capture_compare_b;
  reg [PRE_W-1:0] pre_reg;
  reg ext_fall_reg;
  reg seen_run_reg;
  reg prev_a_reg;
  reg prev_b_reg;
  reg cap_a_pend_reg;
  reg cap_b_pend_reg;
  reg irq_a_pend_reg;
  reg irq_b_pend_reg;
  reg ovf_zone_reg;
  reg [31:0] rd_next;
  reg rd_hit;

  wire lvl_a;
  wire lvl_b;
  wire running;
  wire [1:0] clk_sel;
  wire [1:0] es_a;
  wire [1:0] es_b;
  wire [PRE_W-1:0] mask;
  wire pre_rise;
  wire pre_fall;
  wire ext_clk;
  wire tick_8;
  wire sample_a;
  wire a_edge;
  wire b_edge;
  wire cnt_rise;
  wire cnt_fall;
  wire trig_b;
  wire trig_a;
  wire match_clr;
  wire match_a;
  wire match_b;
  wire roll;
  wire setup_ph;
  wire wr_acc;
  wire ovf_clr;

  // ----------------------------------------
  // Field decode and count clock
  // ----------------------------------------

  // Mode and edge fields
  assign running = (op_mode_reg != `TCC_OP_STOP);
  assign clk_sel = prescaler_mode_reg[`TCC_PRE_CLK_HI:`TCC_PRE_CLK_LO];
  assign es_a = prescaler_mode_reg[`TCC_PRE_ESA_HI:`TCC_PRE_ESA_LO]; // R3
  assign es_b = prescaler_mode_reg[`TCC_PRE_ESB_HI:`TCC_PRE_ESB_LO];
  assign ext_clk = (clk_sel == `TCC_CLK_INPUT_A);

  // Internal count clock phases from the free prescaler
  assign mask = div_mask(clk_sel);
  assign pre_rise = ((pre_reg & mask) == mask);
  assign pre_fall = ((pre_reg & mask) == (mask >> 1));
  assign tick_8 = ((pre_reg & `TCC_MASK_DIV8) == `TCC_MASK_DIV8);

  // Input A sampled at fx/8 as a clock, at count clock as a trigger
  assign sample_a = ext_clk ? tick_8 : pre_rise; // R16

  // Edges are seen only while running
  assign a_edge = running & edge_hit(es_a, prev_a_reg, lvl_a); // R8
  assign b_edge = running & edge_hit(es_b, prev_b_reg, lvl_b); // R8

  // Count clock rise and fall strobes
  assign cnt_rise = running & (ext_clk ? a_edge : pre_rise);
  assign cnt_fall = running & (ext_clk ? ext_fall_reg : pre_fall);

  // Capture triggers; input A capture barred as clock or on both edges
  assign trig_b = a_edge & capctl_reg[`TCC_CAP_B_BIT] & ~ext_clk & (es_a != `TCC_ES_BOTH); // R9 R10 R14
  assign trig_a = b_edge & capctl_reg[`TCC_CAP_A_BIT]; // R14

  // Compare matches use the register value at the tick
  assign match_a = (main_counter_16 == capture_compare_a); // R6 R13
  assign match_b = (main_counter_16 == capture_compare_b); // R6 R13
  assign match_clr = (op_mode_reg == `TCC_OP_MATCH_CLR) & match_a;
  assign roll = cnt_rise & (main_counter_16 == `TCC_CNT_MAX); // R4

  // APB phases
  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & pready;
  assign ovf_clr = wr_acc & (paddr == `TCC_OFS_MODE) & ~pwdata[`TCC_MODE_OVF_BIT];

  // ----------------------------------------
  // Input filters
  // ----------------------------------------
  tcc_edge_filter u_filt_a (
    .pclk(pclk),
    .presetn(presetn),
    .pin(timer_input_a),
    .sample_tick(sample_a),
    .level(lvl_a)
  );

  tcc_edge_filter u_filt_b (
    .pclk(pclk),
    .presetn(presetn),
    .pin(timer_input_b),
    .sample_tick(pre_rise),
    .level(lvl_b)
  );

  // ----------------------------------------
  // Prescaler and edge history
  // ----------------------------------------

  // Free prescaler, never restarted by timer start
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= {PRE_W{1'b0}};
      ext_fall_reg <= 1'b0;
    end else begin
      pre_reg <= pre_reg + {{(PRE_W-1){1'b0}}, 1'b1}; // R18
      ext_fall_reg <= ext_clk & a_edge;
    end
  end

  // Previous levels stay low until first run after reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_run_reg <= 1'b0;
      prev_a_reg <= 1'b0;
      prev_b_reg <= 1'b0;
    end else begin
      if (running) begin
        seen_run_reg <= 1'b1;
      end
      if (running | seen_run_reg) begin
        prev_a_reg <= lvl_a; // R15
        prev_b_reg <= lvl_b; // R15
      end
    end
  end

  // ----------------------------------------
  // Counter, captures and events
  // ----------------------------------------

  // Up counter with match clear and edge clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_counter_16 <= `TCC_CNT_ZERO; // R19
    end else if (!running) begin
      main_counter_16 <= `TCC_CNT_ZERO;
    end else if ((op_mode_reg == `TCC_OP_EDGE_CLR) & a_edge) begin
      main_counter_16 <= `TCC_CNT_ZERO;
    end else if (cnt_rise) begin
      if (match_clr) begin
        main_counter_16 <= `TCC_CNT_ZERO; // R13
      end else begin
        main_counter_16 <= main_counter_16 + {{(CNT_W-1){1'b0}}, 1'b1}; // R19
      end
    end
  end

  // Capture pending until the count clock falls
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_a_pend_reg <= 1'b0;
      cap_b_pend_reg <= 1'b0;
      irq_a_pend_reg <= 1'b0;
      irq_b_pend_reg <= 1'b0;
    end else begin
      if (cnt_fall & (cap_a_pend_reg | trig_a)) begin
        cap_a_pend_reg <= 1'b0;
        irq_a_pend_reg <= 1'b1; // R12
      end else if (trig_a) begin
        cap_a_pend_reg <= 1'b1;
      end else if (cnt_rise & irq_a_pend_reg) begin
        irq_a_pend_reg <= 1'b0;
      end
      if (cnt_fall & (cap_b_pend_reg | trig_b)) begin
        cap_b_pend_reg <= 1'b0;
        irq_b_pend_reg <= 1'b1; // R2 R12
      end else if (trig_b) begin
        cap_b_pend_reg <= 1'b1;
      end else if (cnt_rise & irq_b_pend_reg) begin
        irq_b_pend_reg <= 1'b0;
      end
      if (!running) begin
        cap_a_pend_reg <= 1'b0;
        cap_b_pend_reg <= 1'b0;
        irq_a_pend_reg <= 1'b0;
        irq_b_pend_reg <= 1'b0;
      end
    end
  end

  // Interrupt pulses on the count clock rise
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_match_irq <= 1'b0;
      capture_b_irq <= 1'b0;
    end else begin
      capture_match_irq <= cnt_rise & (irq_a_pend_reg | (~capctl_reg[`TCC_CAP_A_BIT] & match_a)); // R12
      capture_b_irq <= cnt_rise & (irq_b_pend_reg | (~capctl_reg[`TCC_CAP_B_BIT] & match_b)); // R12
    end
  end

  // Overflow flag; a clear inside the zero count is lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
      ovf_zone_reg <= 1'b0;
    end else begin
      if (roll | (match_clr & cnt_rise & (capture_compare_a == `TCC_CNT_MAX))) begin
        overflow_flag <= 1'b1; // R4
        ovf_zone_reg <= 1'b1;
      end else begin
        if (ovf_clr & ~ovf_zone_reg) begin
          overflow_flag <= 1'b0; // R5
        end
        if (cnt_rise | ~running) begin
          ovf_zone_reg <= 1'b0; // R5
        end
      end
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------

  // Software writes and hardware captures
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_mode_reg <= `TCC_OP_STOP;
      prescaler_mode_reg <= `TCC_RST_BYTE;
      capctl_reg <= 2'h0;
      capture_compare_a <= `TCC_CNT_ZERO;
      capture_compare_b <= `TCC_CNT_ZERO;
    end else begin
      if (wr_acc) begin
        case (paddr)
          `TCC_OFS_MODE: op_mode_reg <= pwdata[`TCC_MODE_OP_HI:`TCC_MODE_OP_LO];
          `TCC_OFS_PRESCALE: prescaler_mode_reg <= pwdata[7:0];
          `TCC_OFS_CAPCTL: capctl_reg <= pwdata[1:0];
          `TCC_OFS_CCA: capture_compare_a <= pwdata[CNT_W-1:0]; // R1 R6
          `TCC_OFS_CCB: capture_compare_b <= pwdata[CNT_W-1:0]; // R1 R6
          default: op_mode_reg <= op_mode_reg;
        endcase
      end
      // Capture wins over a coinciding software write
      if (cnt_fall & (cap_a_pend_reg | trig_a)) begin
        capture_compare_a <= main_counter_16;
      end
      if (cnt_fall & (cap_b_pend_reg | trig_b)) begin
        capture_compare_b <= main_counter_16; // R2
      end
    end
  end

  // Read multiplexer; counter read has no side effect
  always @* begin
    rd_next = 32'h00000000;
    rd_hit = 1'b1;
    case (paddr)
      `TCC_OFS_MODE: rd_next = {28'h0000000, op_mode_reg, 1'b0, overflow_flag};
      `TCC_OFS_PRESCALE: rd_next = {24'h000000, prescaler_mode_reg};
      `TCC_OFS_CAPCTL: rd_next = {30'h00000000, capctl_reg};
      `TCC_OFS_COUNT: rd_next = {16'h0000, main_counter_16}; // R7
      `TCC_OFS_CCA: rd_next = {16'h0000, capture_compare_a};
      `TCC_OFS_CCB: rd_next = {16'h0000, capture_compare_b};
      default: rd_hit = 1'b0;
    endcase
  end

  // APB answer, ready one cycle after setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~rd_hit;
      if (setup_ph & ~pwrite) begin
        prdata <= rd_next;
      end
    end
  end

endmodule // tcc_timer

`default_nettype wire

// ==== shared/tcc_regs.vh ====
`ifndef TCC_REGS_VH
`define TCC_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TCC_OFS_MODE 8'h00
`define TCC_OFS_PRESCALE 8'h04
`define TCC_OFS_CAPCTL 8'h08
`define TCC_OFS_COUNT 8'h0C
`define TCC_OFS_CCA 8'h10
`define TCC_OFS_CCB 8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TCC_MODE_OVF_BIT 0
`define TCC_MODE_OP_HI 3
`define TCC_MODE_OP_LO 2
`define TCC_PRE_CLK_HI 1
`define TCC_PRE_CLK_LO 0
`define TCC_PRE_ESA_HI 5
`define TCC_PRE_ESA_LO 4
`define TCC_PRE_ESB_HI 7
`define TCC_PRE_ESB_LO 6
`define TCC_CAP_A_BIT 0
`define TCC_CAP_B_BIT 1

// ----------------------------------------
// Encodings
// ----------------------------------------
`define TCC_OP_STOP 2'h0
`define TCC_OP_EDGE_CLR 2'h1
`define TCC_OP_FREE 2'h2
`define TCC_OP_MATCH_CLR 2'h3
`define TCC_CLK_FX 2'h0
`define TCC_CLK_FX_DIV4 2'h1
`define TCC_CLK_FX_DIV64 2'h2
`define TCC_CLK_INPUT_A 2'h3
`define TCC_ES_FALL 2'h0
`define TCC_ES_RISE 2'h1
`define TCC_ES_NONE 2'h2
`define TCC_ES_BOTH 2'h3

// ----------------------------------------
// Divider masks and reset values
// ----------------------------------------
`define TCC_MASK_FX 6'h00
`define TCC_MASK_DIV4 6'h03
`define TCC_MASK_DIV64 6'h3F
`define TCC_MASK_DIV8 6'h07
`define TCC_CNT_MAX 16'hFFFF
`define TCC_CNT_ZERO 16'h0000
`define TCC_RST_BYTE 8'h00

`endif

// ==== verification/tcc_pulse_src.sv ====
`timescale 1ns/1ps
`default_nettype none

module tcc_pulse_src (
  // Clock
  input wire logic pclk,
  // Pulse request
  input wire logic fire,
  input wire logic [7:0] width,
  // Pins, pulled low when idle
  output wire logic timer_input_a,
  output wire logic timer_input_b
);
  logic [7:0] left_reg = 8'h00;
  // Hold both pins high for width cycles
  always @(posedge pclk) begin
    if (fire) begin
      left_reg <= width;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end
  end
  assign timer_input_a = (left_reg != 8'h00);
  assign timer_input_b = (left_reg != 8'h00);
endmodule // tcc_pulse_src

`default_nettype wire

// ==== verification/tcc_timer_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.vh"

module tcc_timer_checker #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  // APB answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and events
  input wire logic timer_input_a,
  input wire logic timer_input_b,
  input wire logic capture_match_irq,
  input wire logic capture_b_irq,
  input wire logic overflow_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Bus phases
  // ----------------------------------------
  logic setup_w;
  logic mode_wr;
  // Setup cycle and overflow-clearing access
  assign setup_w = psel && !penable;
  assign mode_wr = psel && penable && pwrite && (paddr == `TCC_OFS_MODE) && !pwdata[`TCC_MODE_OVF_BIT];
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence bad_setup_s;
    setup_s ##0 (paddr > 8'h14 || paddr[1:0] != 2'h0);
  endsequence
  sequence good_setup_s;
    setup_s ##0 (paddr <= 8'h14 && paddr[1:0] == 2'h0);
  endsequence

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  ready_after_setup_a: assert property (setup_s |=> pready) else $error("pready missing after setup");
  ready_cause_a: assert property (pready |-> $past(setup_w)) else $error("pready without setup");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  unmapped_err_a: assert property (bad_setup_s |=> pslverr) else $error("unmapped access not refused");
  mapped_ok_a: assert property (good_setup_s |=> !pslverr) else $error("mapped access refused");
  rdata_hold_a: assert property (!(setup_w && !pwrite) |=> $stable(prdata)) else $error("prdata moved");
  ovf_sticky_a: assert property (overflow_flag && !mode_wr |=> overflow_flag) else $error("flag dropped");
  irq_a_pulse_a: assert property (capture_match_irq |=> !capture_match_irq) else $error("irq a too long");
  irq_b_pulse_a: assert property (capture_b_irq |=> !capture_b_irq) else $error("irq b too long");
endmodule // tcc_timer_checker

`default_nettype wire

// ==== verification/test_tcc_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.vh"

module test_tcc_timer;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic err;} tcc_row_t;
  logic pclk, presetn, psel, penable, pwrite, fire, er;
  logic [7:0] paddr, width;
  logic [31:0] pwdata, rd, v0, c1;
  wire [31:0] prdata;
  wire pready, pslverr, tia, tib, irq_a, irq_b, ovf;
  int err_count, checked, na, nb, n, o0;
  tcc_row_t rows [7] = '{
    '{`TCC_OFS_CCA, 32'hFFFFFFFF, 32'h0000FFFF, 1'b0},
    '{`TCC_OFS_CCB, 32'h12345678, 32'h00005678, 1'b0},
    '{`TCC_OFS_PRESCALE, 32'hFFFFFFFF, 32'h000000FF, 1'b0},
    '{`TCC_OFS_CAPCTL, 32'hFFFFFFFF, 32'h00000003, 1'b0},
    '{`TCC_OFS_MODE, 32'h00000001, 32'h00000000, 1'b0},
    '{`TCC_OFS_COUNT, 32'h0000ABCD, 32'h00000000, 1'b0},
    '{8'h18, 32'hFFFFFFFF, 32'h00000000, 1'b1}};

  // ----------------------------------------
  // Design, pulse source, clock
  // ----------------------------------------
  tcc_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_input_a(tia), .timer_input_b(tib), .capture_match_irq(irq_a), .capture_b_irq(irq_b),
    .overflow_flag(ovf));
  tcc_pulse_src src (.pclk(pclk), .fire(fire), .width(width), .timer_input_a(tia), .timer_input_b(tib));
  always #50 pclk = ~pclk;
  // Count event pulses mid-cycle, where they are settled
  always @(negedge pclk) begin
    if (irq_a === 1'b1) na++;
    if (irq_b === 1'b1) nb++;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task bad(input string m);
    err_count++;
    $display("BAD %0t %s", $time, m);
  endtask
  task chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) bad(m);
  endtask
  task chk_num(input int g, input int e, input string m);
    checked++;
    if (g != e) bad(m);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task cap_case(input logic [1:0] op, input logic [7:0] pre, input logic [1:0] cap, input int ea, input int eb);
    int a0, b0;
    apb(1'b1, `TCC_OFS_MODE, 32'h0);
    apb(1'b1, `TCC_OFS_PRESCALE, {24'h0, pre});
    apb(1'b1, `TCC_OFS_CAPCTL, {30'h0, cap});
    apb(1'b1, `TCC_OFS_MODE, {28'h0, op, 2'h0});
    a0 = na;
    b0 = nb;
    @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (30) @(posedge pclk);
    chk_num(nb - b0, ea, "capture from input A");
    chk_num(na - a0, eb, "capture from input B");
    $display("capture case %h done", pre);
  endtask
  task test_done;
    $display("checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    fire = 0; width = 8'd10; err_count = 0; checked = 0; na = 0; nb = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk_word(rd, 32'h0, "reset value");
    end
    $display("reset test done");
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk_word(rd, rows[i].e, "read back");
      chk_word({31'h0, er}, {31'h0, rows[i].err}, "slave error");
    end
    $display("register table done");
    cap_case(2'h2, 8'h00, 2'h3, 1, 1);
    cap_case(2'h2, 8'h50, 2'h3, 1, 1);
    cap_case(2'h2, 8'hA0, 2'h3, 0, 0);
    cap_case(2'h2, 8'h70, 2'h3, 0, 1);
    cap_case(2'h2, 8'h93, 2'h3, 0, 0);
    cap_case(2'h0, 8'h50, 2'h3, 0, 0);
    // Clear on input A edge: count restarts from the edge
    apb(1'b1, `TCC_OFS_MODE, 32'h0);
    apb(1'b1, `TCC_OFS_PRESCALE, 32'h50);
    apb(1'b1, `TCC_OFS_CAPCTL, 32'h0);
    apb(1'b1, `TCC_OFS_MODE, 32'h4);
    repeat (300) @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (20) @(posedge pclk);
    apb(1'b0, `TCC_OFS_COUNT, 32'h0);
    chk_word({31'h0, rd < 32'd40}, 32'h1, "edge clear");
    $display("edge clear test done");
    // Clear on compare A match: period of ten counts
    apb(1'b1, `TCC_OFS_MODE, 32'h0);
    apb(1'b1, `TCC_OFS_CCA, 32'h9);
    apb(1'b1, `TCC_OFS_CCB, 32'h5);
    apb(1'b1, `TCC_OFS_MODE, 32'hC);
    repeat (20) @(posedge pclk);
    o0 = na;
    n = nb;
    repeat (100) @(posedge pclk);
    chk_num(na - o0, 10, "match clear period A");
    chk_num(nb - n, 10, "match compare B");
    apb(1'b1, `TCC_OFS_MODE, 32'h0);
    $display("match clear test done");
    apb(1'b1, `TCC_OFS_CCA, 32'hFFFF);
    apb(1'b1, `TCC_OFS_CCB, 32'hFFFF);
    cap_case(2'h2, 8'h50, 2'h0, 0, 0);
    apb(1'b1, `TCC_OFS_MODE, 32'h0);
    apb(1'b1, `TCC_OFS_CAPCTL, 32'h2);
    apb(1'b1, `TCC_OFS_PRESCALE, 32'h0);
    apb(1'b1, `TCC_OFS_MODE, 32'h8);
    apb(1'b0, `TCC_OFS_CCB, 32'h0);
    v0 = rd;
    apb(1'b0, `TCC_OFS_COUNT, 32'h0);
    c1 = rd;
    apb(1'b0, `TCC_OFS_COUNT, 32'h0);
    chk_word(rd - c1, 32'h3, "count step");
    apb(1'b0, `TCC_OFS_CCB, 32'h0);
    chk_word(rd, v0, "count read captured");
    $display("count test done");
    o0 = na;
    n = 0;
    while (ovf !== 1'b1 && n < 70000) begin @(posedge pclk); n++; end
    chk_word({31'h0, ovf}, 32'h1, "overflow flag");
    chk_num(na - o0, 1, "match at top count");
    apb(1'b1, `TCC_OFS_MODE, 32'h8);
    apb(1'b0, `TCC_OFS_MODE, 32'h0);
    chk_word(rd, 32'h8, "flag clear");
    $display("overflow test done");
    // Reset in mid-run with both pins held high
    width <= 8'd100;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `TCC_OFS_MODE, 32'h0);
    chk_word(rd, 32'h0, "mode after reset");
    n = nb;
    apb(1'b1, `TCC_OFS_CAPCTL, 32'h2);
    apb(1'b1, `TCC_OFS_PRESCALE, 32'h50);
    apb(1'b1, `TCC_OFS_MODE, 32'h8);
    repeat (10) @(posedge pclk);
    chk_num(nb - n, 1, "edge after reset");
    apb(1'b1, `TCC_OFS_MODE, 32'h0);
    apb(1'b1, `TCC_OFS_MODE, 32'h8);
    repeat (10) @(posedge pclk);
    chk_num(nb - n, 1, "edge after restart");
    $display("start edge test done");
    apb(1'b1, `TCC_OFS_MODE, 32'h0);
    apb(1'b0, `TCC_OFS_COUNT, 32'h0);
    chk_word(rd, 32'h0, "count after stop");
    test_done;
  end
  // Cut a hang short
  initial begin
    #8000000;
    bad("timeout");
    test_done;
  end
endmodule // test_tcc_timer

bind tcc_timer tcc_timer_checker #(.ADDR_W(ADDR_W)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timer_input_a(timer_input_a), .timer_input_b(timer_input_b),
  .capture_match_irq(capture_match_irq), .capture_b_irq(capture_b_irq), .overflow_flag(overflow_flag));

`default_nettype wire
